// *** pkg/core_exec_map.svh ***
// constants of the instruction-execute block: encodings, field positions,
// register offsets and reset values; included wherever they are needed
`ifndef CORE_EXEC_MAP_SVH
`define CORE_EXEC_MAP_SVH

// word and field widths
`define IW_W          14
`define PC_W          13
`define DATA_W        8
`define FADDR_W       7
`define FILE_DEPTH    128
`define STACK_DEPTH   8
`define STACK_PTR_W   3

// instruction encodings (fixed bits and masks)
`define SKIP_MASK     14'h3C00
`define SKIP_CODE     14'h1C00
`define KICK_CODE     14'h0064
`define CALL_MASK     14'h3800
`define CALL_CODE     14'h2000
`define INV_MASK      14'h3F00
`define INV_CODE      14'h0900
`define ZREG_MASK     14'h3F80
`define ZREG_CODE     14'h0180
`define ZACC_MASK     14'h3F80
`define ZACC_CODE     14'h0100
`define DEC_MASK      14'h3F00
`define DEC_CODE      14'h0300

// operand fields
`define F_LSB         0
`define D_BIT         7
`define B_LSB         7
`define K_W           11
`define PCL_HI_LSB    3

// register port offsets (byte addresses of an 8-bit space)
`define ADDR_CTRL     8'h00
`define ADDR_STATUS   8'h01
`define ADDR_ACC      8'h02
`define ADDR_PCLATCH  8'h03
`define ADDR_PC_LO    8'h04
`define ADDR_PC_HI    8'h05
`define ADDR_WDOG     8'h06
`define ADDR_HEAD_LO  8'h07
`define ADDR_HEAD_HI  8'h08
`define FILE_SEL_BIT  7

// control bits
`define CTRL_RUN      0
`define CTRL_WDOG_EN  1

// status bits
`define ST_ZERO       2
`define ST_SLEEP      3
`define ST_EXPIRY     4

// reset values
`define CTRL_RST      8'h00
`define STATUS_RST    8'h18
`define PC_RST        13'h0000
`define WDOG_RST      8'h00
`define PRESC_RST     8'h00
`define ACC_RST       8'h00
`define PCLATCH_RST   5'h00
`endif

// *** pkg/core_exec_pkg.sv ***
// types shared by the instruction-execute block and its submodules
package core_exec_pkg;

    typedef enum {
        OP_NONE,
        OP_SKIP_IF_BIT_ONE,
        OP_KICK_WATCHDOG,
        OP_CALL,
        OP_INVERT_REG,
        OP_ZERO_REG,
        OP_REG_DECREMENT,
        OP_ZERO_ACC
    } op_t;

    // one decoded instruction word
    typedef struct packed {
        logic [10:0] k;
        logic [6:0] f;
        logic [2:0] b;
        logic d;
    } operand_t;

    // one data-file write
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

endpackage

// *** logic/data_file.sv ***
// data register file: 128 bytes, two combinational read ports, one write
// port; lives on the core clock, written only through the port below
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_map.svh"

module data_file
    import core_exec_pkg::*;
(
    // clock
    input wire logic clk_i,
    input wire logic ce_i,
    // write
    input wire file_wr_t wr_i,
    // reads
    input wire logic [`FADDR_W-1:0] core_addr_i,
    output logic [`DATA_W-1:0] core_data_o,
    input wire logic [`FADDR_W-1:0] sw_addr_i,
    output logic [`DATA_W-1:0] sw_data_o
);

    // no reset: contents are undefined after power-up, as in any data ram
    logic [`DATA_W-1:0] mem_q [`FILE_DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (ce_i && wr_i.en)
        begin
            mem_q[wr_i.addr] <= wr_i.data;
        end
    end

    assign core_data_o = mem_q[core_addr_i];
    assign sw_data_o = mem_q[sw_addr_i];

endmodule
`default_nettype wire

// *** logic/return_stack.sv ***
// return stack: eight 13-bit entries, circular, push only from this block;
// the head is held in a flip-flop so it can leave the top directly
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_map.svh"

module return_stack
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // push
    input wire logic push_i,
    input wire logic [`PC_W-1:0] data_i,
    // head
    output logic [`PC_W-1:0] head_o
);

    logic [`PC_W-1:0] entry_q [`STACK_DEPTH];
    logic [`STACK_PTR_W-1:0] ptr_q;
    logic [`PC_W-1:0] head_q;

    // a ninth push overwrites the oldest entry, no overflow flag exists
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ptr_q <= '0;
            head_q <= '0;
        end
        else if (ce_i && push_i)
        begin
            ptr_q <= ptr_q + 3'h1;
            head_q <= data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i && push_i)
        begin
            entry_q[ptr_q] <= data_i;
        end
    end

    assign head_o = head_q;

endmodule
`default_nettype wire

// *** logic/core_exec.sv ***
// instruction execute for one group of single-word instructions: fetch by
// pc_o, decode, act on the data file, accumulator, status, stack, watchdog.
// assumes program memory returns the word at pc_o in the same cycle.
//
// Function
// - bit set: discard next, run a NOP
// - watchdog kick loads counter with zero
// - watchdog kick clears the prescaler too
// - watchdog kick sets expiry and sleep bits
// - call pushes pc plus one first
// - call loads eleven-bit operand into pc low
// - call takes pc high from latch bits
// - call takes two cycles, flags unchanged
// - invert writes complement, updates zero flag
// - zero register writes 00h, sets zero flag
// - decrement writes f minus one, zero only
// - zero accumulator loads 00h, sets zero flag
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_map.svh"

module core_exec
    import core_exec_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // program memory
    input wire logic [`IW_W-1:0] instr_i,
    output logic [`PC_W-1:0] pc_o,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    // watchdog and stack
    output logic wdog_expired_o,
    output logic [`PC_W-1:0] stack_head_o
);

    logic [7:0] ctrl_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [`DATA_W-1:0] acc_q;
    logic [`DATA_W-1:0] acc_d;
    logic [4:0] pclatch_q;
    logic [`PC_W-1:0] pc_q;
    logic [`PC_W-1:0] pc_d;
    logic flush_q;
    logic flush_d;
    logic flush_hold_q;
    logic flush_hold_d;
    logic [7:0] wdog_q;
    logic [7:0] presc_q;
    logic wdog_expired_q;
    logic [7:0] rdata_q;
    logic kick;
    logic push;
    logic run;
    logic wdog_tick;
    logic [`DATA_W-1:0] file_rd;
    logic [`DATA_W-1:0] sw_rd;
    logic [`DATA_W-1:0] result;
    logic [`PC_W-1:0] head;
    op_t op;
    operand_t opd;
    file_wr_t core_wr;
    file_wr_t file_wr;

    assign run = ctrl_q[`CTRL_RUN];

    // decode
    always_comb
    begin
        opd.k = instr_i[`K_W-1:0];
        opd.f = instr_i[`F_LSB +: `FADDR_W];
        opd.b = instr_i[`B_LSB +: 3];
        opd.d = instr_i[`D_BIT];
        if ((instr_i & `SKIP_MASK) == `SKIP_CODE)
            op = OP_SKIP_IF_BIT_ONE;
        else if (instr_i == `KICK_CODE)
            op = OP_KICK_WATCHDOG;
        else if ((instr_i & `CALL_MASK) == `CALL_CODE)
            op = OP_CALL;
        else if ((instr_i & `INV_MASK) == `INV_CODE)
            op = OP_INVERT_REG;
        else if ((instr_i & `ZREG_MASK) == `ZREG_CODE)
            op = OP_ZERO_REG;
        else if ((instr_i & `DEC_MASK) == `DEC_CODE)
            op = OP_REG_DECREMENT;
        else if ((instr_i & `ZACC_MASK) == `ZACC_CODE)
            op = OP_ZERO_ACC;
        else
            op = OP_NONE;
    end

    // execute: one word per enabled cycle while running
    always_comb
    begin
        pc_d = pc_q;
        acc_d = acc_q;
        status_d = status_q;
        flush_d = 1'b0;
        flush_hold_d = 1'b0;
        kick = 1'b0;
        push = 1'b0;
        result = '0;
        core_wr = '0;
        if (run)
        begin
            if (flush_q)
            begin
                // discarded word acts as a NOP
                if (!flush_hold_q)
                    pc_d = pc_q + 13'h0001;
            end
            else
            begin
                // single-cycle default advance
                pc_d = pc_q + 13'h0001;
                unique case (op)
                    OP_SKIP_IF_BIT_ONE:
                    begin
                        if (file_rd[opd.b])
                            flush_d = 1'b1;
                    end
                    OP_KICK_WATCHDOG:
                    begin
                        kick = 1'b1;
                        status_d[`ST_EXPIRY] = 1'b1;
                        status_d[`ST_SLEEP] = 1'b1;
                    end
                    OP_CALL:
                    begin
                        push = 1'b1;
                        pc_d = {pclatch_q[`PCL_HI_LSB +: 2], opd.k};
                        flush_d = 1'b1;
                        flush_hold_d = 1'b1;
                    end
                    OP_INVERT_REG:
                    begin
                        result = ~file_rd;
                        status_d[`ST_ZERO] = (result == 8'h00);
                    end
                    OP_ZERO_REG:
                    begin
                        result = 8'h00;
                        status_d[`ST_ZERO] = 1'b1;
                    end
                    OP_REG_DECREMENT:
                    begin
                        result = file_rd - 8'h01;
                        status_d[`ST_ZERO] = (result == 8'h00);
                    end
                    OP_ZERO_ACC:
                    begin
                        acc_d = 8'h00;
                        status_d[`ST_ZERO] = 1'b1;
                    end
                    OP_NONE:
                    begin
                    end
                endcase
                // destination select
                if (op == OP_INVERT_REG || op == OP_REG_DECREMENT)
                begin
                    if (opd.d)
                        core_wr = '{en: 1'b1, addr: opd.f, data: result};
                    else
                        acc_d = result;
                end
                if (op == OP_ZERO_REG)
                    core_wr = '{en: 1'b1, addr: opd.f, data: result};
            end
        end
        // a kick in the overflow cycle suppresses the expiry, so no clear here
        if (wdog_tick)
            status_d[`ST_EXPIRY] = 1'b0;
    end

    // software may write the file only while the core is stopped
    always_comb
    begin
        if (run)
            file_wr = core_wr;
        else
            file_wr = '{en: we_i && addr_i[`FILE_SEL_BIT],
                        addr: addr_i[`FADDR_W-1:0], data: wdata_i};
    end

    data_file u_data_file (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .wr_i(file_wr),
        .core_addr_i(opd.f),
        .core_data_o(file_rd),
        .sw_addr_i(addr_i[`FADDR_W-1:0]),
        .sw_data_o(sw_rd)
    );

    return_stack u_return_stack (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .push_i(push),
        .data_i(pc_q + 13'h0001),
        .head_o(head)
    );

    // program counter and flush state
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_q <= `PC_RST;
            flush_q <= 1'b0;
            flush_hold_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pc_q <= pc_d;
            flush_q <= flush_d;
            flush_hold_q <= flush_hold_d;
        end
    end

    // accumulator and status; a software write wins unless the core changes the accumulator value
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q <= `ACC_RST;
            status_q <= `STATUS_RST;
        end
        else if (ce_i)
        begin
            status_q <= status_d;
            if (we_i && addr_i == `ADDR_ACC && acc_d == acc_q)
                acc_q <= wdata_i;
            else
                acc_q <= acc_d;
        end
    end

    // software-owned control and upper pc latch
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_q <= `CTRL_RST;
            pclatch_q <= `PCLATCH_RST;
        end
        else if (ce_i && we_i)
        begin
            if (addr_i == `ADDR_CTRL)
                ctrl_q <= wdata_i & 8'h03;
            if (addr_i == `ADDR_PCLATCH)
                pclatch_q <= wdata_i[4:0];
        end
    end

    // watchdog: prescaler wraps, then the counter advances
    assign wdog_tick = ctrl_q[`CTRL_WDOG_EN] && !kick
        && presc_q == 8'hFF && wdog_q == 8'hFF;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wdog_q <= `WDOG_RST;
            presc_q <= `PRESC_RST;
            wdog_expired_q <= 1'b0;
        end
        else if (ce_i)
        begin
            wdog_expired_q <= wdog_tick;
            if (kick)
            begin
                wdog_q <= 8'h00;
                presc_q <= 8'h00;
            end
            else if (ctrl_q[`CTRL_WDOG_EN])
            begin
                presc_q <= presc_q + 8'h01;
                if (presc_q == 8'hFF)
                    wdog_q <= wdog_q + 8'h01;
            end
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_q <= 8'h00;
        else if (ce_i)
        begin
            if (!re_i)
                rdata_q <= 8'h00;
            else if (addr_i[`FILE_SEL_BIT])
                rdata_q <= sw_rd;
            else
            begin
                unique case (addr_i)
                    `ADDR_CTRL: rdata_q <= ctrl_q;
                    `ADDR_STATUS: rdata_q <= status_q;
                    `ADDR_ACC: rdata_q <= acc_q;
                    `ADDR_PCLATCH: rdata_q <= {3'h0, pclatch_q};
                    `ADDR_PC_LO: rdata_q <= pc_q[7:0];
                    `ADDR_PC_HI: rdata_q <= {3'h0, pc_q[12:8]};
                    `ADDR_WDOG: rdata_q <= wdog_q;
                    `ADDR_HEAD_LO: rdata_q <= head[7:0];
                    `ADDR_HEAD_HI: rdata_q <= {3'h0, head[12:8]};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign pc_o = pc_q;
    assign rdata_o = rdata_q;
    assign wdog_expired_o = wdog_expired_q;
    assign stack_head_o = head;

endmodule
`default_nettype wire

// *** bench/prog_mem_model.sv ***
// program memory model: the word at the program counter, combinational
// assumes the bench loads words only while the core is stopped
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
    // fetch
    input wire logic [12:0] pc_i,
    output logic [13:0] instr_o
);
    // unloaded words read as zero, which the core runs as a no-op
    logic [13:0] mem[8192] = '{default: 14'h0000};
    assign instr_o = mem[pc_i];
endmodule
`default_nettype wire

// *** bench/core_exec_chk.sv ***
// port checker for core_exec, bound to every instance
// assumes one clock domain and ce_i held high
`timescale 1ns/1ps
`default_nettype none
`include "core_exec_map.svh"
module core_exec_chk
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // program memory
    input wire logic [13:0] instr_i,
    input wire logic [12:0] pc_o,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [7:0] rdata_o,
    // watchdog and stack
    input wire logic wdog_expired_o,
    input wire logic [12:0] stack_head_o
);
    logic run_q;
    logic [4:0] latch_q;
    logic br_q;
    logic call_q;
    wire exec = run_q && ce_i;
    wire is_call = (instr_i & `CALL_MASK) == `CALL_CODE;
    wire is_br = is_call || (instr_i & `SKIP_MASK) == `SKIP_CODE;
    // a word after any branch may be flushed, so only clean calls count
    wire go = exec && is_call && !br_q;
    wire kick = exec && instr_i == `KICK_CODE && !br_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            run_q <= 1'b0;
            latch_q <= 5'h00;
            br_q <= 1'b0;
            call_q <= 1'b0;
        end
        else
        begin
            if (we_i && ce_i && addr_i == `ADDR_CTRL)
                run_q <= wdata_i[`CTRL_RUN];
            if (we_i && ce_i && addr_i == `ADDR_PCLATCH)
                latch_q <= wdata_i[4:0];
            br_q <= exec && is_br;
            call_q <= exec && is_call;
        end
    end

    a_call_target: assert property (go |=> pc_o == {$past(latch_q[4:3]), $past(instr_i[10:0])})
        else $error("call target wrong");
    a_call_push: assert property (go |=> stack_head_o == $past(pc_o) + 13'h0001)
        else $error("call return address wrong");
    a_call_hold: assert property (go |=> ##1 $stable(pc_o))
        else $error("call not two cycles");
    a_plain_step: assert property (exec && !is_call && !call_q |=> pc_o == $past(pc_o) + 13'h0001)
        else $error("pc did not step by one");
    a_kick_quiet: assert property (kick |=> !wdog_expired_o [*8])
        else $error("watchdog expired after kick");
    a_head_cause: assert property ($changed(stack_head_o) |-> $past(exec && is_call))
        else $error("stack head moved without call");
    a_status_rsvd: assert property ($past(re_i) && $past(addr_i) == `ADDR_STATUS |-> rdata_o[7:5] == 3'h0 && rdata_o[1:0] == 2'h0)
        else $error("status spare bits set");
    a_read_idle: assert property (!$past(re_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_rd: assert property ($past(re_i) && $past(addr_i) inside {[8'h09:8'h7F]} |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    c_call: cover property (go);
    c_kick: cover property (kick);
    c_expire: cover property (wdog_expired_o);
endmodule

bind core_exec core_exec_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .instr_i(instr_i), .pc_o(pc_o), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .wdog_expired_o(wdog_expired_o),
    .stack_head_o(stack_head_o));
`default_nettype wire

// *** bench/core_exec_bench.sv ***
// self-checking bench for core_exec with a program memory model
// assumes prog_mem_model and core_exec_chk are compiled before it
`timescale 1ns/1ps
`default_nettype none
module core_exec_bench;
    logic clk_i;
    logic reset_n_i;
    logic we_i;
    logic re_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic [12:0] pc_o;
    logic [12:0] stack_head_o;
    logic [13:0] instr_i;
    logic wdog_expired_o;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] r[6];
    logic [31:0] seed;
    int err_count = 0;
    int compares = 0;
    int n;
    // skip taken, skip not taken, invert, decrement, clear, kick, call
    logic [13:0] prog[10] = '{14'h1F90, 14'h0991, 14'h1C10, 14'h0995, 14'h0913,
        14'h0392, 14'h0193, 14'h0314, 14'h0064, 14'h2123};

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    core_exec dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .instr_i(instr_i),
        .pc_o(pc_o), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .wdog_expired_o(wdog_expired_o), .stack_head_o(stack_head_o));
    prog_mem_model mem_u (.pc_i(pc_o), .instr_o(instr_i));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        re_i <= 1'b0;
    endtask

    task automatic results();
        repeat (3) @(posedge clk_i);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_i)
        rd_seen <= re_i;
    always @(negedge clk_i)
        if (rd_seen)
            chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});

    initial
    begin
        seed = 32'h0000ED7D;
        reset_n_i = 1'b0;
        we_i = 1'b0;
        re_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        for (n = 0; n < 6; n++)
            r[n] = rnd();
        r[0] = (r[0] & 8'h7E) | 8'h80;
        r[4] = r[4] | 8'h02;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (n = 0; n < 9; n++)
            rd(n[7:0], n == 1 ? 8'h18 : 8'h00);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h18);
        wr(8'h20, r[5]);
        rd(8'h20, 8'h00);
        wr(8'h03, 8'hF8);
        rd(8'h03, 8'h18);
        for (n = 0; n < 6; n++)
            wr(8'h90 + n[7:0], r[n]);
        for (n = 0; n < 10; n++)
            mem_u.mem[n] = prog[n];
        mem_u.mem[13'h1923] = 14'h0100;
        // let the watchdog expire first so the kick has a bit to set
        wr(8'h00, 8'h02);
        for (n = 0; n < 70000 && wdog_expired_o !== 1'b1; n++)
            @(negedge clk_i);
        if (n == 70000)
        begin
            err_count++;
            results();
        end
        rd(8'h01, 8'h08);
        repeat (600) @(posedge clk_i);
        wr(8'h00, 8'h03);
        repeat (30) @(posedge clk_i);
        wr(8'h00, 8'h00);
        // pc moves at the edge that stops the core, so look once it has settled
        @(negedge clk_i);
        chk({3'h0, stack_head_o}, 16'h000A);
        chk({14'h0, pc_o[12:11]}, 16'h0003);
        rd(8'h01, 8'h1C);
        rd(8'h02, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h0A);
        rd(8'h08, 8'h00);
        rd(8'h90, r[0]);
        rd(8'h91, r[1]);
        rd(8'h92, r[2] - 8'h01);
        rd(8'h93, 8'h00);
        rd(8'h94, r[4]);
        rd(8'h95, ~r[5]);
        // second reset: the data file keeps its contents
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (n = 1; n < 10; n++)
            mem_u.mem[n] = 14'h0000;
        mem_u.mem[0] = 14'h0314;
        wr(8'h00, 8'h01);
        repeat (5) @(posedge clk_i);
        wr(8'h00, 8'h00);
        rd(8'h02, r[4] - 8'h01);
        rd(8'h01, 8'h18);
        results();
    end
endmodule
`default_nettype wire
